// [hw/sdc_defines.svh]
// Constants for the SDRAM pin command interface
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// =============================================================
// Mode register fields
`define SDC_MODE_BL_LSB 0
`define SDC_MODE_BL_W 3
`define SDC_MODE_BT_BIT 3
`define SDC_MODE_CL_LSB 4
`define SDC_MODE_CL_W 3
`define SDC_MODE_WB_BIT 9
`define SDC_MODE_RST 11'h020

// =============================================================
// Address fields
`define SDC_AUTO_PRECHARGE_BIT 10
`define SDC_COL_W 8
`define SDC_ROW_W 11
`define SDC_BANK_W 2
`define SDC_MEM_WORDS 2097152

// =============================================================
// Burst length codes and lengths
`define SDC_BL_CODE_1 3'h0
`define SDC_BL_CODE_2 3'h1
`define SDC_BL_CODE_4 3'h2
`define SDC_BL_CODE_8 3'h3
`define SDC_BL_CODE_PAGE 3'h7
`define SDC_PAGE_BEATS 9'h100

// =============================================================
// Timing in clock cycles and init refresh count
`define SDC_DQZ_LAT 2
`define SDC_INIT_REFRESHES 2'h2

`endif

// [hw/sdc_pkg.sv]
// Types for the SDRAM pin command interface
package sdc_pkg;

  // ===========================================================
  // Command code from ras, cas, we with chip select low
  typedef enum logic [2:0] {
    SDC_CMD_LMR = 3'b000,
    SDC_CMD_REF = 3'b001,
    SDC_CMD_PRE = 3'b010,
    SDC_CMD_ACT = 3'b011,
    SDC_CMD_WR = 3'b100,
    SDC_CMD_RD = 3'b101,
    SDC_CMD_BST = 3'b110,
    SDC_CMD_NOP = 3'b111
  } sdc_cmd_t;

  // ===========================================================
  // Clock gate states
  typedef enum logic [2:0] {
    SDC_PWR_RUN = 3'b000,
    SDC_PWR_SUSPEND = 3'b001,
    SDC_PWR_ACT_PD = 3'b010,
    SDC_PWR_PRE_PD = 3'b011,
    SDC_PWR_SELF_REF = 3'b100
  } sdc_pwr_t;

  // ===========================================================
  // Command pins sampled on each rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [10:0] addr;
  } sdc_cmd_pins_t;

  // ===========================================================
  // Device status
  typedef struct packed {
    sdc_pwr_t pwr;
    logic [10:0] mode;
    logic [3:0] bank_open;
    logic burst_active;
    logic init_done;
  } sdc_status_t;

endpackage

// [hw/sdc_device.sv]
// SDRAM device pin command interface: decoder, banks, bursts, masks, clock gate
`timescale 1ns/10ps
`include "sdc_defines.svh"

// Summary of operation
// - All inputs and bursts advance on rising edge
// - Clock gate low freezes; selects power state
// - Power-down or self refresh ignore all but gate
// - Chip select high masks commands, bursts continue
// - Command is select plus three strobes together
// - Masked byte lanes are not written
// - Read mask floats lane two cycles later
// - Mask bit n covers data byte n
// - Bank select picks bank for commands
// - Row on activate, column and autoprecharge on access
// - Precharge closes one bank or all
// - Load mode takes op-code from address
// - Write mask applies with zero latency
module sdc_device (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Command pins
  input wire logic cke_i,
  input sdc_pkg::sdc_cmd_pins_t cmd_i,
  input wire logic [3:0] dqm_i,
  // Data pins
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic [3:0] dq_oe_o,
  // Status
  output sdc_pkg::sdc_status_t status_o
);
  import sdc_pkg::*;

  // ===========================================================
  // State
  typedef struct packed {
    sdc_pwr_t pwr;
    logic [10:0] mode;
    logic [3:0] open;
    logic [3:0][10:0] row;
    logic [1:0] ref_cnt;
    logic bst_on;
    logic bst_wr;
    logic bst_ap;
    logic [1:0] bst_bank;
    logic [7:0] bst_start;
    logic [8:0] bst_cnt;
    logic [2:0] rd_vld;
    logic [2:0][31:0] rd_dat;
    logic [3:0] dqm1;
    logic [3:0] dqm2;
    logic [31:0] dq_out;
    logic [3:0] dq_oe;
  } sdc_state_t;

  sdc_state_t s_q;
  sdc_state_t s_d;
  logic [31:0] mem_q [0:`SDC_MEM_WORDS-1];
  logic wr_en;
  logic [20:0] wr_idx;
  logic [3:0] wr_be;
  logic [31:0] wr_data;
  logic [20:0] rd_idx;
  logic [31:0] rd_word;

  // ===========================================================
  // Helpers
  function automatic logic [8:0] sdc_beats(input logic [10:0] mode, input logic wr);
    logic [2:0] code;
    code = mode[`SDC_MODE_BL_LSB +: `SDC_MODE_BL_W];
    if (wr && mode[`SDC_MODE_WB_BIT]) begin
      sdc_beats = 9'h001;
    end else begin
      unique case (code)
        `SDC_BL_CODE_2: sdc_beats = 9'h002;
        `SDC_BL_CODE_4: sdc_beats = 9'h004;
        `SDC_BL_CODE_8: sdc_beats = 9'h008;
        `SDC_BL_CODE_PAGE: sdc_beats = `SDC_PAGE_BEATS;
        default: sdc_beats = 9'h001;
      endcase
    end
  endfunction

  function automatic logic [7:0] sdc_col(input logic [7:0] start, input logic [8:0] cnt,
                                         input logic [10:0] mode);
    logic [7:0] lin;
    logic [7:0] msk;
    logic [7:0] low;
    lin = start + cnt[7:0];
    unique case (mode[`SDC_MODE_BL_LSB +: `SDC_MODE_BL_W])
      `SDC_BL_CODE_2: msk = 8'h01;
      `SDC_BL_CODE_4: msk = 8'h03;
      `SDC_BL_CODE_8: msk = 8'h07;
      `SDC_BL_CODE_PAGE: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
    if (mode[`SDC_MODE_BT_BIT] && (msk != 8'hFF)) begin
      low = start ^ cnt[7:0];
    end else begin
      low = lin;
    end
    sdc_col = (start & ~msk) | (low & msk);
  endfunction

  function automatic logic [20:0] sdc_idx(input logic [1:0] bank, input logic [10:0] row,
                                          input logic [7:0] col);
    sdc_idx = {bank, row, col};
  endfunction

  // ===========================================================
  // Next state
  always_comb begin
    logic en;
    sdc_cmd_t cmd;
    logic b_on;
    logic b_wr;
    logic b_ap;
    logic [1:0] b_bank;
    logic [7:0] b_start;
    logic [8:0] b_cnt;
    logic [7:0] col;
    logic [1:0] sel;
    logic [8:0] beats;
    en = 1'b0;
    cmd = SDC_CMD_NOP;
    b_on = 1'b0;
    b_wr = 1'b0;
    b_ap = 1'b0;
    b_bank = 2'h0;
    b_start = 8'h00;
    b_cnt = 9'h000;
    col = 8'h00;
    sel = 2'h0;
    beats = 9'h000;
    s_d = s_q;
    wr_en = 1'b0;
    wr_idx = 21'h000000;
    wr_be = 4'h0;
    wr_data = dq_i;
    rd_idx = 21'h000000;
    en = (s_q.pwr == SDC_PWR_RUN);
    if (en) begin
      // Command decode only with chip select low
      if (!cmd_i.cs_n) begin
        cmd = sdc_cmd_t'({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n});
      end
      s_d.dqm1 = dqm_i;
      s_d.dqm2 = s_q.dqm1;
      // Burst beat source: running burst or new access
      b_on = s_q.bst_on;
      b_wr = s_q.bst_wr;
      b_ap = s_q.bst_ap;
      b_bank = s_q.bst_bank;
      b_start = s_q.bst_start;
      b_cnt = s_q.bst_cnt;
      unique case (cmd)
        SDC_CMD_RD, SDC_CMD_WR: begin
          b_on = 1'b1;
          b_wr = (cmd == SDC_CMD_WR);
          b_ap = cmd_i.addr[`SDC_AUTO_PRECHARGE_BIT];
          b_bank = cmd_i.ba;
          b_start = cmd_i.addr[7:0];
          b_cnt = 9'h000;
        end
        SDC_CMD_BST: b_on = 1'b0;
        SDC_CMD_PRE: begin
          if (cmd_i.addr[`SDC_AUTO_PRECHARGE_BIT] || (cmd_i.ba == s_q.bst_bank)) begin
            b_on = 1'b0;
          end
        end
        default: begin
        end
      endcase
      // Issue one beat of the burst
      beats = sdc_beats(s_q.mode, b_wr);
      col = sdc_col(b_start, b_cnt, s_q.mode);
      rd_idx = sdc_idx(b_bank, s_q.row[b_bank], col);
      s_d.rd_vld[0] = b_on && !b_wr;
      s_d.rd_dat[0] = rd_word;
      s_d.rd_vld[2:1] = s_q.rd_vld[1:0];
      s_d.rd_dat[2:1] = s_q.rd_dat[1:0];
      if (b_on && b_wr) begin
        wr_en = 1'b1;
        wr_idx = rd_idx;
        wr_be = ~dqm_i;
      end
      s_d.bst_wr = b_wr;
      s_d.bst_ap = b_ap;
      s_d.bst_bank = b_bank;
      s_d.bst_start = b_start;
      s_d.bst_cnt = b_cnt + 9'h001;
      s_d.bst_on = b_on;
      if (b_on && ((b_cnt + 9'h001) == beats)) begin
        if (beats == `SDC_PAGE_BEATS && s_q.mode[`SDC_MODE_BL_LSB +: `SDC_MODE_BL_W] ==
            `SDC_BL_CODE_PAGE && !(b_wr && s_q.mode[`SDC_MODE_WB_BIT])) begin
          s_d.bst_cnt = 9'h000;
        end else begin
          s_d.bst_on = 1'b0;
          if (b_ap) begin
            s_d.open[b_bank] = 1'b0;
          end
        end
      end
      // Bank, mode and refresh commands
      unique case (cmd)
        SDC_CMD_ACT: begin
          s_d.open[cmd_i.ba] = 1'b1;
          s_d.row[cmd_i.ba] = cmd_i.addr;
        end
        SDC_CMD_PRE: begin
          if (cmd_i.addr[`SDC_AUTO_PRECHARGE_BIT]) begin
            s_d.open = 4'h0;
          end else begin
            s_d.open[cmd_i.ba] = 1'b0;
          end
        end
        SDC_CMD_LMR: s_d.mode = cmd_i.addr;
        SDC_CMD_REF: begin
          if (s_q.ref_cnt != `SDC_INIT_REFRESHES) begin
            s_d.ref_cnt = s_q.ref_cnt + 2'h1;
          end
        end
        default: begin
        end
      endcase
      // Output stage at the programmed read latency
      unique case (s_q.mode[`SDC_MODE_CL_LSB +: `SDC_MODE_CL_W])
        3'h1: sel = 2'h0;
        3'h2: sel = 2'h1;
        default: sel = 2'h2;
      endcase
      s_d.dq_out = s_q.rd_dat[sel];
      s_d.dq_oe = {4{s_q.rd_vld[sel]}} & ~s_q.dqm2;
      // Clock gate low: pick the low power state
      if (!cke_i) begin
        if (cmd == SDC_CMD_REF && s_q.open == 4'h0) begin
          s_d.pwr = SDC_PWR_SELF_REF;
        end else if (s_d.bst_on || s_q.rd_vld != 3'h0) begin
          s_d.pwr = SDC_PWR_SUSPEND;
        end else if (s_d.open != 4'h0) begin
          s_d.pwr = SDC_PWR_ACT_PD;
        end else begin
          s_d.pwr = SDC_PWR_PRE_PD;
        end
      end
    end else begin
      // Frozen: only the clock gate is watched
      if (cke_i) begin
        s_d.pwr = SDC_PWR_RUN;
      end
    end
  end

  // ===========================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.mode <= `SDC_MODE_RST;
      s_q.pwr <= SDC_PWR_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // Storage read port
  // Word under the current beat address, taken into the read pipe
  assign rd_word = mem_q[rd_idx];

  // ===========================================================
  // Storage array, byte-lane writes

  always_ff @(posedge sys_clk_i) begin
    if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_be[i]) begin
          mem_q[wr_idx][8*i +: 8] <= wr_data[8*i +: 8];
        end
      end
    end
  end

  // ===========================================================
  // Data outputs
  assign dq_o = s_q.dq_out;
  assign dq_oe_o = s_q.dq_oe;

  // ===========================================================
  // Status outputs
  assign status_o.pwr = s_q.pwr;
  assign status_o.mode = s_q.mode;
  assign status_o.bank_open = s_q.open;
  assign status_o.burst_active = s_q.bst_on;
  assign status_o.init_done = (s_q.ref_cnt == `SDC_INIT_REFRESHES);

endmodule // sdc_device

// [tb/sdc_device_asserts.sv]
// Pin-level checks of the SDRAM device
`timescale 1ns/10ps
module sdc_device_asserts import sdc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Device pins
  input wire logic cke_i,
  input sdc_cmd_pins_t cmd_i,
  input wire logic [3:0] dqm_i,
  input wire logic [31:0] dq_i,
  input wire logic [31:0] dq_o,
  input wire logic [3:0] dq_oe_o,
  input sdc_status_t status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic run;
  logic go;
  logic [2:0] op;
  assign run = status_o.pwr == SDC_PWR_RUN;
  assign go = run && !cmd_i.cs_n;
  assign op = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  sequence s_live;
    run && cke_i;
  endsequence
  sequence s_asleep;
    !run && !cke_i;
  endsequence
  // ==========================================================
  // Checks
  a_load_mode_op: assert property (go && op == SDC_CMD_LMR |=>
    status_o.mode == $past(cmd_i.addr)) else $error("mode not taken from address");
  a_select_high_ignored: assert property (run && cmd_i.cs_n |=>
    $stable(status_o.mode)) else $error("command taken with select high");
  a_act_opens_bank: assert property (go && op == SDC_CMD_ACT |=>
    status_o.bank_open[$past(cmd_i.ba)]) else $error("bank not opened");
  a_pre_all_banks: assert property (go && op == SDC_CMD_PRE && cmd_i.addr[10] |=>
    status_o.bank_open == 4'h0) else $error("banks left open");
  a_pre_one_bank: assert property (go && op == SDC_CMD_PRE && !cmd_i.addr[10] |=>
    !status_o.bank_open[$past(cmd_i.ba)]) else $error("bank not closed");
  a_sleep_frozen: assert property (s_asleep |=> $stable(status_o.bank_open) &&
    $stable(status_o.mode) && $stable(dq_oe_o)) else $error("state moved while asleep");
  a_wake_one_edge: assert property (!run && cke_i |=> run)
    else $error("no wake after gate high");
  a_read_mask_float: assert property (s_live ##1 s_live ##1 run |=>
    (dq_oe_o & $past(dqm_i, 3)) == 4'h0) else $error("masked lane driven");
endmodule // sdc_device_asserts

bind sdc_device sdc_device_asserts chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .cke_i(cke_i),
  .cmd_i(cmd_i),
  .dqm_i(dqm_i),
  .dq_i(dq_i),
  .dq_o(dq_o),
  .dq_oe_o(dq_oe_o),
  .status_o(status_o)
);

// [tb/sdc_ctrl_model.sv]
// Memory controller model driving the device pins
`timescale 1ns/10ps
module sdc_ctrl_model import sdc_pkg::*; #(
  parameter int INIT_WAIT = 25000
) (
  // Clock
  input wire logic sys_clk_i,
  // Pins toward the device
  output logic cke_o,
  output sdc_cmd_pins_t cmd_o,
  output logic [3:0] dqm_o,
  output logic [31:0] dq_o
);
  initial begin
    cke_o = 1'b1;
    cmd_o = '1;
    dqm_o = 4'h0;
    dq_o = 32'h0;
  end
  // One command slot, all pins changed together
  task automatic issue(input sdc_cmd_t op, input logic [1:0] ba, input logic [10:0] a,
    input logic [3:0] m, input logic [31:0] d, input logic cs_n, input logic cke);
    @(negedge sys_clk_i);
    cmd_o = {cs_n, op, ba, a};
    dqm_o = m;
    dq_o = d;
    cke_o = cke;
  endtask
  task automatic idle(input logic [3:0] m);
    issue(SDC_CMD_NOP, 2'h0, 11'h000, m, ~dq_o, 1'b0, 1'b1);
  endtask
  task automatic init();
    repeat (INIT_WAIT) idle(4'h0);
    repeat (2) issue(SDC_CMD_REF, 2'h0, 11'h000, 4'h0, ~dq_o, 1'b0, 1'b1);
  endtask
  task automatic load(input logic [10:0] a);
    issue(SDC_CMD_LMR, 2'h0, a, 4'h0, ~dq_o, 1'b0, 1'b1);
    repeat (2) idle(4'h0);
  endtask
endmodule // sdc_ctrl_model

// [tb/test_sdram_pin_command_interface.sv]
// Testbench of the SDRAM device pins
`timescale 1ns/10ps
module test_sdram_pin_command_interface;
  import sdc_pkg::*;
  logic clk, rst_n, cke;
  logic [3:0] dqm, dq_oe;
  logic [31:0] dq_w, dq_r;
  sdc_cmd_pins_t cmd;
  sdc_status_t st;
  int n_errors, n_tests, cycles;
  logic [31:0] wa [4];
  logic [31:0] wb [4];
  sdc_cmd_t pop [3] = '{SDC_CMD_NOP, SDC_CMD_REF, SDC_CMD_NOP};
  sdc_pwr_t pst [3] = '{SDC_PWR_PRE_PD, SDC_PWR_SELF_REF, SDC_PWR_ACT_PD};
  sdc_ctrl_model ctl_u (.sys_clk_i(clk), .cke_o(cke), .cmd_o(cmd), .dqm_o(dqm), .dq_o(dq_w));
  sdc_device dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .cke_i(cke), .cmd_i(cmd), .dqm_i(dqm),
    .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe), .status_o(st));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 26000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr4(input logic [31:0] d [4], input logic [3:0] m1);
    ctl_u.issue(SDC_CMD_WR, 2'h2, 11'h010, 4'h0, d[0], 1'b0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      ctl_u.issue(SDC_CMD_NOP, 2'h0, 11'h000, (i == 1) ? m1 : 4'h0, d[i], 1'b0, 1'b1);
    end
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    cycles = 0;
    n_errors = 0;
    n_tests = 0;
    for (int i = 0; i < 4; i++) begin
      wa[i] = 32'hA5A50000 + i;
      wb[i] = 32'h3C3C3C00 + i;
    end
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    ctl_u.init();
    ctl_u.load(11'h022);
    check("mode", st.mode, 32'h022);
    check("init done", st.init_done, 32'h1);
    ctl_u.issue(SDC_CMD_ACT, 2'h2, 11'h005, 4'h0, 32'h0, 1'b0, 1'b1);
    ctl_u.idle(4'h0);
    check("open after act", st.bank_open, 32'h4);
    wr4(wa, 4'h0);
    wr4(wb, 4'h1);
    ctl_u.issue(SDC_CMD_RD, 2'h2, 11'h010, 4'h0, 32'h0, 1'b0, 1'b1);
    ctl_u.idle(4'h0);
    ctl_u.idle(4'h5);
    ctl_u.idle(4'h0);
    for (int i = 0; i < 4; i++) begin
      check("read oe", dq_oe, (i == 2) ? 4'hA : 4'hF);
      if (i != 2) check("read data", dq_r, (i == 1) ? {wb[1][31:8], wa[1][7:0]} : wb[i]);
      ctl_u.idle(4'h0);
    end
    check("oe after burst", dq_oe, 32'h0);
    check("burst done", st.burst_active, 32'h0);
    ctl_u.issue(SDC_CMD_LMR, 2'h0, 11'h7FF, 4'h0, 32'h0, 1'b1, 1'b1);
    ctl_u.issue(SDC_CMD_ACT, 2'h1, 11'h000, 4'h0, 32'h0, 1'b1, 1'b1);
    ctl_u.idle(4'h0);
    check("mode kept", st.mode, 32'h022);
    check("banks kept", st.bank_open, 32'h4);
    ctl_u.issue(SDC_CMD_ACT, 2'h0, 11'h003, 4'h0, 32'h0, 1'b0, 1'b1);
    ctl_u.issue(SDC_CMD_PRE, 2'h2, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
    ctl_u.idle(4'h0);
    check("one closed", st.bank_open, 32'h1);
    ctl_u.issue(SDC_CMD_PRE, 2'h2, 11'h400, 4'h0, 32'h0, 1'b0, 1'b1);
    ctl_u.idle(4'h0);
    check("all closed", st.bank_open, 32'h0);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) ctl_u.issue(SDC_CMD_ACT, 2'h1, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
      ctl_u.issue(pop[i], 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
      ctl_u.issue(SDC_CMD_ACT, 2'h3, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
      ctl_u.issue(SDC_CMD_NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
      check("power state", st.pwr, pst[i]);
      check("frozen banks", st.bank_open, (i == 2) ? 4'h2 : 4'h0);
      ctl_u.idle(4'h0);
      ctl_u.idle(4'h0);
      check("woken", st.pwr, SDC_PWR_RUN);
    end
    report_and_stop();
  end
endmodule // test_sdram_pin_command_interface
